// [include/log_read_pkg.sv]
// Package with the shared constants of the extended log read command path.
package log_read_pkg;
    // Command code and task-file fields.
    localparam logic [7:0]  CMD_READ_LOG_EXT   = 8'h2F;
    localparam logic [7:0]  LOG_DIRECTORY      = 8'h00;
    localparam logic [7:0]  LOG_EXT_ERROR      = 8'h03;
    localparam logic [7:0]  LOG_SELFTEST_OLD   = 8'h06;
    localparam logic [7:0]  LOG_EXT_SELFTEST   = 8'h07;
    localparam logic [7:0]  LOG_POWER_COND     = 8'h08;
    localparam logic [7:0]  LOG_QUEUED_ERROR   = 8'h10;
    localparam logic [7:0]  LOG_PHY_EVENTS     = 8'h11;
    localparam logic [7:0]  LOG_QUEUE_MGMT     = 8'h12;
    localparam logic [7:0]  LOG_REBUILD_ASSIST = 8'h15;
    localparam logic [7:0]  LOG_WRITE_STREAM   = 8'h21;
    localparam logic [7:0]  LOG_READ_STREAM    = 8'h22;
    localparam logic [7:0]  LOG_IDENTIFY       = 8'h30;
    localparam logic [7:0]  LOG_VENDOR_FIRST   = 8'h80;
    localparam logic [7:0]  LOG_VENDOR_LAST    = 8'h9F;
    // Sizes of logs in sectors.
    localparam logic [15:0] LOG_VENDOR_SECTORS = 16'h0010;
    localparam logic [15:0] LOG_OTHER_SECTORS  = 16'h0001;
    // Index of the last word in a 512-byte sector on a 16-bit data path.
    localparam logic [7:0]  WORDS_PER_SECTOR   = 8'hFF;
    // Feature set enable bit positions.
    localparam int FS_SMART_ERR = 0;
    localparam int FS_SELFTEST  = 1;
    localparam int FS_POWER     = 2;
    localparam int FS_NCQ       = 3;
    localparam int FS_PHY       = 4;
    localparam int FS_QMGMT     = 5;
    localparam int FS_STREAM    = 6;
    localparam int FS_SMART     = 7;
    localparam int FS_REBUILD   = 8;
    localparam int FS_WIDTH     = 9;
    // Status and error bit positions.
    localparam int ST_ERR = 0;
    localparam int ST_DRQ = 3;
    localparam int ST_RDY = 6;
    localparam int ST_BSY = 7;
    localparam int ER_ABT = 2;
    // Host register map.
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_ADDR   = 12'h004;
    localparam logic [11:0] REG_COUNT  = 12'h008;
    localparam logic [11:0] REG_START  = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_IRQ_ST = 12'h014;
    localparam logic [11:0] REG_IRQ_MK = 12'h018;
    localparam logic [11:0] REG_DATA   = 12'h01C;
    localparam logic [11:0] REG_WORDS  = 12'h020;
    // Interrupt status bit positions.
    localparam int IRQ_BLOCK = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_ABORT = 2;
endpackage

// [include/log_link_if.sv]
// Interface joining the host task-file port with the drive's log command logic.
`timescale 1ns/1ps
interface log_link_if;
    logic        cmd_valid;   // Host issues a command, one-cycle pulse.
    logic [7:0]  cmd_code;    // Command register value.
    logic [15:0] sec_count;   // Previous and current sector count fields.
    logic [7:0]  sec_number;  // Current sector number field.
    logic [15:0] cyl_low;     // Previous and current cylinder low fields.
    logic        data_valid;  // Drive offers a data word.
    logic [15:0] data;        // Data word.
    logic        data_ready;  // Host takes the data word.
    logic        intrq;       // Host interrupt pulse.
    logic [7:0]  status;      // Status register image.
    logic [7:0]  error;       // Error register image.
    modport drive (input cmd_valid, cmd_code, sec_count, sec_number, cyl_low, data_ready,
                   output data_valid, data, intrq, status, error);
    modport host  (output cmd_valid, cmd_code, sec_count, sec_number, cyl_low, data_ready,
                   input data_valid, data, intrq, status, error);
endinterface

// [hdl/log_read_drive.sv]
// Drive end: decodes the extended log read command and returns log sectors.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Code 2Fh requests a log read.
// - Interrupt once per transferred data block.
// - Sector count: low current, high previous.
// - Log address in current sector number.
// - First sector: low current, high previous.
// - Transfer starts at the requested sector.
// - Supported logs including vendor 80h-9Fh.
// - Log address 06h always aborts.
// - Abort on disabled feature or bad fields.
// - Serial-link logs 10h,11h,12h,15h assigned.
// - Extended self-test holds both entry sizes.
module log_read_drive
    import log_read_pkg::*;
(
    // Clock and reset.
    input  wire logic                                   sys_clk_i,
    input  wire logic                                   srst_i,
    // Link to the host.
    log_link_if.drive                                   link,
    // Feature set enables and log storage read port.
    input  wire logic [log_read_pkg::FS_WIDTH-1:0]      feat_en_i,
    output logic      [7:0]                             mem_log_o,
    output logic      [15:0]                            mem_sector_o,
    output logic      [7:0]                             mem_word_o,
    input  wire logic [15:0]                            mem_data_i
);
    // The sequencer waits in idle, streams the
    // accepted sectors, then rests one cycle.
    // One-hot: one flip-flop for each state.
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_XFER = 3'b010,
        S_DONE = 3'b100
    } drv_state_e;

    // Registers first, then the decode results.
    drv_state_e  state_q;      // Command sequencer state.
    logic [15:0] left_q;       // Sectors still to send.
    logic [7:0]  word_q;       // Word index inside the sector.
    logic [15:0] sector_q;     // Current log sector.
    logic [7:0]  log_q;        // Selected log.
    logic        aborted_q;    // Last command ended aborted.
    logic        irq_q;        // Interrupt pulse register.
    // Combinational judgement of the command fields.
    logic        valid;        // Field check passed.
    logic        fs_ok;        // Owning feature set enabled.
    logic [15:0] log_size;     // Size of selected log in sectors.
    logic        known;        // Address is a supported log.
    logic        take;         // Word handed over this cycle.

    // Map each log address to its feature set and size.
    // Only the sector number field picks the log; any
    // address no branch names, 06h too, is refused.
    always_comb begin
        // Defaults: a known, enabled one-sector log.
        known    = 1'b1;
        fs_ok    = 1'b1;
        log_size = LOG_OTHER_SECTORS;
        case (link.sec_number)
            // Directory and identify data need no feature.
            LOG_DIRECTORY, LOG_IDENTIFY: fs_ok = 1'b1;
            // Other logs follow their feature set enable.
            LOG_EXT_ERROR:      fs_ok = feat_en_i[FS_SMART_ERR];
            // The extended self-test sector carries 48-bit and 28-bit entries alike
            LOG_EXT_SELFTEST:   fs_ok = feat_en_i[FS_SELFTEST];
            LOG_POWER_COND:     fs_ok = feat_en_i[FS_POWER];
            // Serial-link logs; 13h, 14h, 16h, 17h reserved.
            LOG_QUEUED_ERROR:   fs_ok = feat_en_i[FS_NCQ];
            LOG_PHY_EVENTS:     fs_ok = feat_en_i[FS_PHY];
            LOG_QUEUE_MGMT:     fs_ok = feat_en_i[FS_QMGMT];
            LOG_REBUILD_ASSIST: fs_ok = feat_en_i[FS_REBUILD];
            // Both stream error logs share one enable.
            LOG_WRITE_STREAM, LOG_READ_STREAM: fs_ok = feat_en_i[FS_STREAM];
            default: begin
                // Vendor logs: a block of addresses, 16 sectors.
                if (link.sec_number >= LOG_VENDOR_FIRST && link.sec_number <= LOG_VENDOR_LAST) begin
                    fs_ok    = feat_en_i[FS_SMART];
                    log_size = LOG_VENDOR_SECTORS;
                end else begin
                    // Reserved addresses and 06h are not served here.
                    known = 1'b0;
                end
            end
        endcase
    end

    // A request must fit inside the log from its first sector on.
    // One bit wider, so a high start cannot wrap.
    // A zero count is refused: nothing to send.
    // Counts running past the log end are refused.
    assign valid = known && fs_ok && (link.sec_count != 16'h0000)
                   && ({1'b0, link.cyl_low} + {1'b0, link.sec_count} <= {1'b0, log_size});

    // A word leaves while offered and the host has room.
    assign take = (state_q == S_XFER) && link.data_ready;

    // Command sequencer.
    // A command outside idle is ignored, so the
    // host waits one cycle after DRQ falls before the next.
    // Refusal is judged from the fields as they stand.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Reset abandons any transfer.
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // Leave only for an accepted command.
                    if (link.cmd_valid && link.cmd_code == CMD_READ_LOG_EXT && valid) begin
                        state_q <= S_XFER;
                    end
                end
                S_XFER: begin
                    // Until the last word of the last sector.
                    if (take && word_q == WORDS_PER_SECTOR && left_q == 16'h0001) begin
                        state_q <= S_DONE;
                    end
                end
                // One cycle with DRQ low; no command taken.
                S_DONE: state_q <= S_IDLE;
                // Stray codes return to idle.
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Transfer counters; the sector count only bounds the length.
    // Fields latch even for a refused command and
    // then go unused. The address stays stable if
    // the host rewrites its registers mid-transfer.
    // Sectors are counted down to zero.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Storage address defined out of reset.
            left_q   <= 16'h0000;
            word_q   <= 8'h00;
            sector_q <= 16'h0000;
            log_q    <= 8'h00;
        end else if (state_q == S_IDLE && link.cmd_valid) begin
            // Latch the request as the command is seen.
            left_q   <= link.sec_count;
            sector_q <= link.cyl_low;
            log_q    <= link.sec_number;
            word_q   <= 8'h00;
        end else if (take) begin
            // Word index wraps from 255 to 0 per sector.
            word_q <= word_q + 8'h01;
            if (word_q == WORDS_PER_SECTOR) begin
                // Sector done: count it, move to the next.
                left_q   <= left_q - 16'h0001;
                sector_q <= sector_q + 16'h0001;
            end
        end
    end

    // Abort flag for status; any other command code also aborts.
    // It stands until the next command, so software
    // can read the reason after the interrupt.
    // An accepted command clears it.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aborted_q <= 1'b0;
        end else if (state_q == S_IDLE && link.cmd_valid) begin
            // Wrong code, bad field or disabled log.
            aborted_q <= !(link.cmd_code == CMD_READ_LOG_EXT && valid);
        end
    end

    // One interrupt as each block is offered, and one at an abort.
    // The first comes with the command; each later
    // block is announced as the one before it ends.
    // None follows the last block: DRQ falls instead.
    // Registered, so decode glitches never reach it.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Nothing pending out of reset.
            irq_q <= 1'b0;
        end else begin
            // Any command seen in idle, or a block end other than the last.
            irq_q <= (state_q == S_IDLE && link.cmd_valid)
                     || (take && word_q == WORDS_PER_SECTOR && left_q != 16'h0001);
        end
    end

    // Data comes combinationally from storage; the host waits on valid.
    // The word always matches the registered address.
    // Limit: storage must answer in one clock period.
    // The storage address is the transfer registers.
    assign link.data_valid = (state_q == S_XFER);
    assign link.data       = mem_data_i;
    assign link.intrq      = irq_q;
    assign mem_log_o       = log_q;
    assign mem_sector_o    = sector_q;
    assign mem_word_o      = word_q;

    // Status and error images.
    // Never busy: a command is judged the cycle
    // it arrives. Ready stays high throughout.
    always_comb begin
        link.status         = 8'h00;
        link.status[ST_BSY] = 1'b0;
        link.status[ST_RDY] = 1'b1;
        link.status[ST_DRQ] = (state_q == S_XFER);
        link.status[ST_ERR] = aborted_q;
        // The abort code stands together with ERR.
        link.error          = 8'h00;
        link.error[ER_ABT]  = aborted_q;
    end
endmodule

// [hdl/log_read_host.sv]
// Host end: APB-programmed controller issuing the extended log read command.
`timescale 1ns/1ps
module log_read_host
    import log_read_pkg::*;
(
    // Clock and reset.
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    // APB slave.
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [11:0]  paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Interrupt.
    output logic              irq_o,
    // Link to the drive.
    log_link_if.host          link
);
    logic [7:0]  addr_q;     // Log address to request.
    logic [15:0] count_q;    // Sector count to request.
    logic [15:0] start_q;    // First sector to request.
    logic [2:0]  ist_q;      // Sticky interrupt status.
    logic [2:0]  imk_q;      // Interrupt mask.
    logic [15:0] data_q;     // Last word received.
    logic        full_q;     // Word held for software.
    logic [31:0] words_q;    // Words received since last command.
    logic        issue_q;    // Command pulse register.
    logic        drq_q;      // DRQ one cycle ago.
    logic        wr;         // APB write access.
    logic        rd;         // APB read access.
    logic        mapped;     // Address decodes.

    assign wr     = psel_i && penable_i && pwrite_i;
    assign rd     = psel_i && penable_i && !pwrite_i;
    assign mapped = paddr_i inside {REG_CTRL, REG_ADDR, REG_COUNT, REG_START, REG_STATUS,
                                    REG_IRQ_ST, REG_IRQ_MK, REG_DATA, REG_WORDS};
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // Task-file fields held by software.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            addr_q  <= 8'h00;
            count_q <= 16'h0000;
            start_q <= 16'h0000;
            imk_q   <= 3'h0;
        end else if (wr) begin
            if (paddr_i == REG_ADDR)   addr_q  <= pwdata_i[7:0];
            if (paddr_i == REG_COUNT)  count_q <= pwdata_i[15:0];
            if (paddr_i == REG_START)  start_q <= pwdata_i[15:0];
            if (paddr_i == REG_IRQ_MK) imk_q   <= pwdata_i[2:0];
        end
    end

    // Writing one to the control word issues the command.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            issue_q <= 1'b0;
        end else begin
            issue_q <= wr && paddr_i == REG_CTRL && pwdata_i[0];
        end
    end

    assign link.cmd_valid  = issue_q;
    assign link.cmd_code   = CMD_READ_LOG_EXT;
    assign link.sec_count  = count_q;
    assign link.sec_number = addr_q;
    assign link.cyl_low    = start_q;
    // Back-pressure: a word stays with the drive until software drained the last.
    assign link.data_ready = !full_q;

    // One-word receive holding register, freed by reading the data word.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            full_q  <= 1'b0;
            data_q  <= 16'h0000;
            words_q <= 32'h0;
        end else begin
            if (link.data_valid && !full_q) begin
                data_q  <= link.data;
                words_q <= words_q + 32'h1;
            end else if (issue_q) begin
                words_q <= 32'h0;
            end
            if (link.data_valid && !full_q) full_q <= 1'b1;
            else if (rd && paddr_i == REG_DATA) full_q <= 1'b0;
        end
    end

    // No interrupt follows the last block, so the end shows as DRQ falling.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            drq_q <= 1'b0;
        end else begin
            drq_q <= link.status[ST_DRQ];
        end
    end

    // Sticky events: set wins over a clear by writing one.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ist_q <= 3'h0;
        end else begin
            ist_q <= (ist_q & ~((wr && paddr_i == REG_IRQ_ST) ? pwdata_i[2:0] : 3'h0))
                     | {link.intrq && link.status[ST_ERR],
                        drq_q && !link.status[ST_DRQ],
                        link.intrq && link.status[ST_DRQ]};
        end
    end

    assign irq_o = |(ist_q & imk_q);

    // Read data register.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                REG_ADDR:   prdata_o <= {24'h0, addr_q};
                REG_COUNT:  prdata_o <= {16'h0, count_q};
                REG_START:  prdata_o <= {16'h0, start_q};
                REG_STATUS: prdata_o <= {15'h0, full_q, link.error, link.status};
                REG_IRQ_ST: prdata_o <= {29'h0, ist_q};
                REG_IRQ_MK: prdata_o <= {29'h0, imk_q};
                REG_DATA:   prdata_o <= {16'h0, data_q};
                REG_WORDS:  prdata_o <= words_q;
                default:    prdata_o <= 32'h0;
            endcase
        end
    end
endmodule

// [verif/log_read_chk.sv]
// Concurrent checks on the link between the host and drive ends of the log read path.
`timescale 1ns/1ps
module log_read_chk
    import log_read_pkg::*;
(
    // Clock and reset.
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    // Link signals, watched only.
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] sec_count,
    input wire logic [7:0]  sec_number,
    input wire logic [15:0] cyl_low,
    input wire logic        data_valid,
    input wire logic [15:0] data,
    input wire logic        data_ready,
    input wire logic        intrq,
    input wire logic [7:0]  status,
    input wire logic [7:0]  error
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // A command counts while no word is offered, idle or the rest cycle; one sent mid-transfer is ignored.
    logic take;
    assign take = cmd_valid && !data_valid;

    a_log06_aborts: assert property (take && sec_number == LOG_SELFTEST_OLD |=> status[ST_ERR] && error[ER_ABT])
        else $error("log 06h was not aborted");
    a_dir_accepted: assert property (take && cmd_code == CMD_READ_LOG_EXT && sec_number == LOG_DIRECTORY
        && sec_count == 16'h0001 && cyl_low == 16'h0000 |=> data_valid && status[ST_DRQ] && !status[ST_ERR])
        else $error("directory read not accepted");
    a_cmd_intr: assert property (take |=> intrq)
        else $error("no interrupt after command");
    a_zero_count: assert property (take && sec_count == 16'h0000 |=> !data_valid && error[ER_ABT])
        else $error("zero count not aborted");
    a_start_beyond: assert property (take && sec_number == LOG_DIRECTORY && cyl_low != 16'h0000 |=> error[ER_ABT])
        else $error("start past end of one-sector log not aborted");
    a_word_held: assert property (data_valid && !data_ready |=> data_valid && $stable(data))
        else $error("offered word changed before it was taken");
    a_intr_pulse: assert property (intrq |=> !intrq)
        else $error("interrupt longer than one cycle");
    a_drq_level: assert property (status[ST_DRQ] == data_valid)
        else $error("data request flag disagrees with transfer");
    a_abort_idle: assert property (status[ST_ERR] |-> !data_valid && error[ER_ABT])
        else $error("error status without abort code or with data");

    // Main scenarios that the bench is expected to reach.
    c_accept: cover property (take ##1 data_valid);
    c_abort: cover property (take ##1 error[ER_ABT]);
    c_block_intr: cover property (data_valid && data_ready ##1 intrq && data_valid);
endmodule

// [verif/test_log_read_command.sv]
// Self-checking bench for the log read path with host and drive ends joined.
`timescale 1ns/1ps
module test_log_read_command;
    import log_read_pkg::*;
    // Clock, reset and APB stimulus.
    logic                sys_clk_i, srst_i, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata;
    // Drive side: feature enables and log storage.
    logic [FS_WIDTH-1:0] fe;
    logic [7:0]          m_log, m_word;
    logic [15:0]         m_sec, m_data;
    int                  num_errors = 0, tests_run = 0, n_intr = 0;
    // Log ids swept once each, supported and refused mixed.
    logic [7:0]          logs [13] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15,
                                       8'h21, 8'h22, 8'h30};

    log_link_if log_link_if_i ();
    log_read_host log_read_host_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .link(log_link_if_i));
    log_read_drive log_read_drive_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(log_link_if_i),
        .feat_en_i(fe), .mem_log_o(m_log), .mem_sector_o(m_sec), .mem_word_o(m_word), .mem_data_i(m_data));
    log_read_chk log_read_chk_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid(log_link_if_i.cmd_valid),
        .cmd_code(log_link_if_i.cmd_code), .sec_count(log_link_if_i.sec_count),
        .sec_number(log_link_if_i.sec_number), .cyl_low(log_link_if_i.cyl_low),
        .data_valid(log_link_if_i.data_valid), .data(log_link_if_i.data), .data_ready(log_link_if_i.data_ready),
        .intrq(log_link_if_i.intrq), .status(log_link_if_i.status), .error(log_link_if_i.error));

    // Storage stand-in: each word encodes its log, sector and position, so order slips show.
    assign m_data = {m_log ^ m_sec[7:0], m_word};

    function automatic logic [15:0] exp_word(input logic [7:0] lg, input logic [15:0] s, input logic [7:0] w);
        return {lg ^ s[7:0], w};
    endfunction

    // Whether the drive should accept a request; vendor logs hold 16 sectors, the rest one.
    function automatic bit exp_ok(input logic [7:0] lg, input logic [15:0] c, s, input logic [FS_WIDTH-1:0] f);
        int b;
        b = -1;
        case (lg)
            8'h00, 8'h30: b = -1;
            8'h03: b = FS_SMART_ERR;
            8'h07: b = FS_SELFTEST;
            8'h08: b = FS_POWER;
            8'h10: b = FS_NCQ;
            8'h11: b = FS_PHY;
            8'h12: b = FS_QMGMT;
            8'h15: b = FS_REBUILD;
            8'h21, 8'h22: b = FS_STREAM;
            default: begin
                if (lg < LOG_VENDOR_FIRST || lg > LOG_VENDOR_LAST) return 1'b0;
                b = FS_SMART;
            end
        endcase
        if (b >= 0 && !f[b]) return 1'b0;
        return c != 16'h0000 && 17'(s) + 17'(c) <= (lg[7] ? 17'd16 : 17'd1);
    endfunction

    // Clock at 100 MHz.
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Interrupt pulses seen on the link, counted per command.
    always @(posedge sys_clk_i) begin
        if (log_link_if_i.intrq === 1'b1) n_intr <= n_intr + 1;
    end

    task give_verdict;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads status until a word waits or the command ended in error, bounded.
    task automatic poll(output logic [31:0] r);
        logic e;
        int k;
        k = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, r, e);
            k++;
        end while (r[16] !== 1'b1 && r[ST_ERR] !== 1'b1 && k < 64);
        if (r[16] !== 1'b1 && r[ST_ERR] !== 1'b1) begin
            num_errors++;
            $display("BAD %0t status poll limit", $time);
        end
    endtask

    // Issues one read of a log and drains or checks the refusal.
    task automatic run_cmd(input logic [7:0] lg, input logic [15:0] c, s, input logic [FS_WIDTH-1:0] f);
        logic [31:0] r;
        logic        e;
        int          n0;
        bit          ok;
        ok = exp_ok(lg, c, s, f);
        fe <= f;
        apb(1'b1, REG_ADDR, {24'h0, lg}, r, e);
        apb(1'b1, REG_COUNT, {16'h0, c}, r, e);
        apb(1'b1, REG_START, {16'h0, s}, r, e);
        apb(1'b1, REG_IRQ_ST, 32'h7, r, e);
        n0 = n_intr;
        apb(1'b1, REG_CTRL, 32'h1, r, e);
        // Let the issue pulse and the answer land first.
        repeat (2) @(posedge sys_clk_i);
        poll(r);
        chk(r[ST_ERR], !ok, "abort flag");
        chk(r[8+ER_ABT], !ok, "abort code");
        for (int w = 0; ok && w < 256 * c; w++) begin
            poll(r);
            apb(1'b0, REG_DATA, 32'h0, r, e);
            chk(r[15:0], exp_word(lg, 16'(s + w / 256), w[7:0]), "log word");
        end
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk(r[ST_DRQ], 1'b0, "transfer end");
        chk(n_intr - n0, ok ? c : 1, "interrupt count");
        apb(1'b0, REG_WORDS, 32'h0, r, e);
        chk(r, ok ? 32'(256 * c) : 32'h0, "word count");
        apb(1'b0, REG_IRQ_ST, 32'h0, r, e);
        chk(r[2:0], ok ? 3'b011 : 3'b100, "irq status");
    endtask

    // Watchdog sized well above the expected run length.
    initial begin
        #1_000_000;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict;
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  lg;
        int          k;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fe = '1;
        srst_i = 1'b1;
        r = $urandom(32'h9499);
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk(r[7:0], 8'h40, "status after reset");
        apb(1'b0, 12'h040, 32'h0, r, e);
        chk(e, 1'b1, "unmapped error");
        chk(r, 32'h0, "unmapped read");
        foreach (logs[i]) run_cmd(logs[i], 16'h0001, 16'h0000, '1);
        run_cmd(LOG_VENDOR_LAST, 16'h0002, 16'h000E, '1);
        run_cmd(LOG_VENDOR_FIRST, 16'h0002, 16'h000F, '1);
        run_cmd(LOG_DIRECTORY, 16'h0000, 16'h0000, '1);
        // Random mixes of log, count, start and feature enables.
        repeat (6) begin
            k = $urandom % 14;
            lg = (k == 13) ? 8'(LOG_VENDOR_FIRST + $urandom % 32) : logs[k];
            run_cmd(lg, 16'($urandom % 3), 16'($urandom % (lg[7] ? 16 : 2)), FS_WIDTH'($urandom));
        end
        // Interrupt masking and clearing on a pending abort event.
        run_cmd(LOG_SELFTEST_OLD, 16'h0001, 16'h0000, '1);
        apb(1'b1, REG_IRQ_MK, 32'h0, r, e);
        apb(1'b0, REG_IRQ_ST, 32'h0, r, e);
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, REG_IRQ_MK, 32'h4, r, e);
        apb(1'b0, REG_IRQ_ST, 32'h0, r, e);
        chk(irq, 1'b1, "unmasked irq");
        apb(1'b1, REG_IRQ_ST, 32'h4, r, e);
        apb(1'b0, REG_IRQ_ST, 32'h0, r, e);
        chk(irq, 1'b0, "cleared irq");
        give_verdict;
    end
endmodule
